// File: design/mcode_load_defs.vh
`ifndef MCODE_LOAD_DEFS_VH
`define MCODE_LOAD_DEFS_VH

// sequencer state codes
`define ST_IDLE 3'h0
`define ST_SPINUP 3'h1
`define ST_LOAD 3'h2
`define ST_PWROFF 3'h3
`define ST_RESET 3'h4
`define ST_STOPPED 3'h5

// control storage sizing, in bytes, with the step also given as a shift count
`define CS_BASE_BYTES 17'h08000
`define CS_STEP_BYTES 17'h00800
`define CS_STEP_SHIFT 11

// image and word defaults
`define IMG_WORDS_DEF 16'h5000
`define WORD_BYTES 4
`define RESET_CYCLES_DEF 16'h0010

`endif

// File: design/cs_alloc_calc.v
`include "mcode_load_defs.vh"
`default_nettype none

// turns a byte requirement into control-storage allocation and program-storage loss
module cs_alloc_calc #(
    parameter AW = 20
) (
    input wire [AW-1:0] need_bytes_i,
    output wire [AW-1:0] alloc_bytes_o,
    output wire [AW-1:0] borrow_bytes_o
) ;
    wire [AW-1:0] base = {{(AW-17){1'b0}}, `CS_BASE_BYTES};
    wire [AW-1:0] step_mask = {{(AW-17){1'b0}}, `CS_STEP_BYTES - 17'h00001};
    wire over = need_bytes_i > base;
    // round the excess up to whole steps; at or below base nothing is borrowed
    wire [AW-1:0] rounded = (need_bytes_i + step_mask) & ~step_mask;
    assign alloc_bytes_o = over ? rounded : base;
    assign borrow_bytes_o = over ? (rounded - base) : {AW{1'b0}};
endmodule

`default_nettype wire

// File: design/microcode_load_sequencer.v
`include "mcode_load_defs.vh"
`default_nettype none

module microcode_load_sequencer #(
    parameter DW = 32,
    parameter CSAW = 16,
    parameter AW = 20,
    parameter [15:0] RESET_CYCLES = `RESET_CYCLES_DEF
) (
    input wire clock_i,
    input wire rst_b_i,
    input wire start_key_i,
    input wire diag_req_i,
    input wire ext_start_i,
    input wire [15:0] image_words_i,
    input wire drive_at_speed_i,
    input wire disk_valid_i,
    input wire [DW-1:0] disk_data_i,
    output reg disk_ready_o,
    output reg drive_power_o,
    output reg boot_load_lamp_o,
    output reg diag_active_o,
    output reg cs_we_o,
    output reg [CSAW-1:0] cs_addr_o,
    output reg [DW-1:0] cs_data_o,
    output reg sys_reset_o,
    output reg cpu_stopped_o,
    output reg [AW-1:0] cs_alloc_o,
    output reg [AW-1:0] ps_borrow_o
) ;
    // two-stage synchronisers for the key, diagnostic, speed and external-start inputs
    // a key tap shorter than one clock period may be missed by the first stage
    reg [1:0] key_s1_reg, key_s2_reg;
    reg key_prev_reg;
    reg diag_s1_reg, diag_s2_reg, diag_prev_reg;
    reg spd_s1_reg, spd_s2_reg;
    reg ext_s1_reg, ext_s2_reg;
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            key_s1_reg <= 2'h0;
            key_s2_reg <= 2'h0;
            key_prev_reg <= 1'b0;
            diag_s1_reg <= 1'b0;
            diag_s2_reg <= 1'b0;
            diag_prev_reg <= 1'b0;
            spd_s1_reg <= 1'b0;
            spd_s2_reg <= 1'b0;
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
        end else begin
            key_s1_reg <= {1'b0, start_key_i};
            key_s2_reg <= key_s1_reg;
            key_prev_reg <= key_s2_reg[0];
            diag_s1_reg <= diag_req_i;
            diag_s2_reg <= diag_s1_reg;
            diag_prev_reg <= diag_s2_reg;
            spd_s1_reg <= drive_at_speed_i;
            spd_s2_reg <= spd_s1_reg;
            ext_s1_reg <= ext_start_i;
            ext_s2_reg <= ext_s1_reg;
        end
    end

    // rising edges only, so a held key cannot retrigger a boot
    wire key_rise = key_s2_reg[0] & ~key_prev_reg;
    wire diag_rise = diag_s2_reg & ~diag_prev_reg;

    // sequencer state; counts are 16 bits, so an image holds at most 65535 words
    reg [2:0] state_reg, state_next;
    reg pending_reg; // power-up boot request, set by reset
    reg diag_mode_reg;
    reg [15:0] words_reg; // image length latched at boot or diagnostic start
    reg [15:0] count_reg;
    reg [15:0] rst_cnt_reg;

    // byte requirement of the image, for the allocation calculator
    // the product is formed at 32 bits and cut to AW on purpose
    wire [31:0] need_prod = words_reg * `WORD_BYTES;
    wire [AW-1:0] need_bytes = need_prod[AW-1:0];
    wire [AW-1:0] alloc_w, borrow_w;
    cs_alloc_calc #(
        .AW(AW)
    ) u_alloc (
        .need_bytes_i(need_bytes),
        .alloc_bytes_o(alloc_w),
        .borrow_bytes_o(borrow_w)
    );

    // boot and load qualifiers; a word is taken only while ready is offered
    wire boot_trig = pending_reg | key_rise;
    wire take_word = (state_reg == `ST_LOAD) & disk_valid_i & disk_ready_o;
    wire last_word = take_word & (count_reg == words_reg - 16'h0001);

    // state transitions
    always @* begin
        state_next = state_reg;
        case (state_reg)
            `ST_IDLE, `ST_STOPPED: begin
                if (boot_trig || diag_rise) begin
                    state_next = `ST_SPINUP;
                end else if ((state_reg == `ST_STOPPED) && ext_s2_reg) begin
                    // external action releases the stop for good, not only while held
                    state_next = `ST_IDLE;
                end
            end
            `ST_SPINUP: begin
                if (spd_s2_reg) begin
                    state_next = (words_reg == 16'h0000) ? `ST_PWROFF : `ST_LOAD;
                end
            end
            `ST_LOAD: begin
                if (last_word) begin
                    state_next = `ST_PWROFF;
                end
            end
            `ST_PWROFF: begin
                state_next = diag_mode_reg ? `ST_STOPPED : `ST_RESET;
            end
            `ST_RESET: begin
                if (rst_cnt_reg == RESET_CYCLES - 16'h0001) begin
                    state_next = `ST_STOPPED;
                end
            end
            default: begin
                state_next = `ST_IDLE;
            end
        endcase
    end

    // sequencer registers and outputs
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= `ST_IDLE;
            pending_reg <= 1'b1;
            diag_mode_reg <= 1'b0;
            words_reg <= 16'h0000;
            count_reg <= 16'h0000;
            rst_cnt_reg <= 16'h0000;
            disk_ready_o <= 1'b0;
            drive_power_o <= 1'b0;
            boot_load_lamp_o <= 1'b0;
            diag_active_o <= 1'b0;
            cs_we_o <= 1'b0;
            cs_addr_o <= {CSAW{1'b0}};
            cs_data_o <= {DW{1'b0}};
            sys_reset_o <= 1'b0;
            cpu_stopped_o <= 1'b0;
            cs_alloc_o <= {{(AW-17){1'b0}}, `CS_BASE_BYTES};
            ps_borrow_o <= {AW{1'b0}};
        end else begin
            state_reg <= state_next;
            cs_we_o <= 1'b0;
            case (state_reg)
                `ST_IDLE, `ST_STOPPED: begin
                    cpu_stopped_o <= (state_reg == `ST_STOPPED) & ~ext_s2_reg;
                    if (boot_trig || diag_rise) begin
                        pending_reg <= 1'b0;
                        diag_mode_reg <= ~boot_trig; // boot wins over diagnostic
                        words_reg <= image_words_i;
                        count_reg <= 16'h0000;
                        boot_load_lamp_o <= boot_trig;
                        diag_active_o <= ~boot_trig;
                        drive_power_o <= 1'b1;
                        cpu_stopped_o <= 1'b0;
                    end
                end
                `ST_SPINUP: begin
                    disk_ready_o <= spd_s2_reg & (words_reg != 16'h0000);
                end
                `ST_LOAD: begin
                    if (take_word) begin
                        cs_we_o <= 1'b1;
                        cs_addr_o <= count_reg[CSAW-1:0];
                        cs_data_o <= disk_data_i;
                        count_reg <= count_reg + 16'h0001;
                        if (last_word) begin
                            disk_ready_o <= 1'b0;
                        end
                    end
                end
                `ST_PWROFF: begin
                    drive_power_o <= 1'b0;
                    disk_ready_o <= 1'b0;
                    diag_active_o <= 1'b0;
                    rst_cnt_reg <= 16'h0000;
                    // the storage boundary only moves on a boot, never on a diagnostic load
                    if (!diag_mode_reg) begin
                        sys_reset_o <= 1'b1;
                        cs_alloc_o <= alloc_w;
                        ps_borrow_o <= borrow_w;
                    end else begin
                        cpu_stopped_o <= 1'b1;
                    end
                end
                `ST_RESET: begin
                    // routine length is RESET_CYCLES; zero is not a legal setting
                    rst_cnt_reg <= rst_cnt_reg + 16'h0001;
                    if (state_next == `ST_STOPPED) begin
                        sys_reset_o <= 1'b0;
                        boot_load_lamp_o <= 1'b0;
                        cpu_stopped_o <= 1'b1;
                    end
                end
                default: begin
                    drive_power_o <= 1'b0;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// File: verification/microcode_load_sequencer_sva.sv
`default_nettype none
module mls_checker (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic drive_at_speed_i,
    input wire logic disk_valid_i,
    input wire logic [31:0] disk_data_i,
    input wire logic disk_ready_o,
    input wire logic drive_power_o,
    input wire logic boot_load_lamp_o,
    input wire logic diag_active_o,
    input wire logic cs_we_o,
    input wire logic [15:0] cs_addr_o,
    input wire logic [31:0] cs_data_o,
    input wire logic sys_reset_o,
    input wire logic cpu_stopped_o,
    input wire logic [19:0] cs_alloc_o
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge clock_i); endclocking
default disable iff (!rst_b_i);
property p_lamp_power; $rose(boot_load_lamp_o) |-> drive_power_o; endproperty
a_lamp_power: assert property (p_lamp_power) else $error("lamp without power");
property p_ready_speed; $rose(disk_ready_o) |-> $past(drive_at_speed_i, 2); endproperty
a_ready_speed: assert property (p_ready_speed) else $error("read before speed");
property p_wr_follow; disk_valid_i && disk_ready_o |=> cs_we_o && cs_data_o == $past(disk_data_i); endproperty
a_wr_follow: assert property (p_wr_follow) else $error("word not written");
property p_wr_cause; cs_we_o |-> $past(disk_valid_i && disk_ready_o); endproperty
a_wr_cause: assert property (p_wr_cause) else $error("stray write");
property p_off_reset; $fell(drive_power_o) && boot_load_lamp_o |-> sys_reset_o; endproperty
a_off_reset: assert property (p_off_reset) else $error("no reset routine");
property p_lamp_off; $fell(sys_reset_o) |-> !boot_load_lamp_o && cpu_stopped_o; endproperty
a_lamp_off: assert property (p_lamp_off) else $error("lamp or stop wrong");
property p_power_only; drive_power_o |-> boot_load_lamp_o || diag_active_o; endproperty
a_power_only: assert property (p_power_only) else $error("drive powered idle");
property p_addr_step; cs_we_o ##1 cs_we_o |-> cs_addr_o == $past(cs_addr_o) + 16'h1; endproperty
a_addr_step: assert property (p_addr_step) else $error("address skip");
property p_alloc; cs_alloc_o[10:0] == 11'h0 && cs_alloc_o >= 20'h08000; endproperty
a_alloc: assert property (p_alloc) else $error("bad allocation");
endmodule
bind microcode_load_sequencer mls_checker chk (.clock_i, .rst_b_i, .drive_at_speed_i,
    .disk_valid_i, .disk_data_i, .disk_ready_o, .drive_power_o, .boot_load_lamp_o,
    .diag_active_o, .cs_we_o, .cs_addr_o, .cs_data_o, .sys_reset_o, .cpu_stopped_o, .cs_alloc_o);
`default_nettype wire

// File: verification/console_disk_model.sv
`default_nettype none
module console_disk_model #(
    parameter int SPIN = 20
) (
    input wire logic clock_i,
    input wire logic power_i,
    input wire logic ready_i,
    input wire logic slow_i,
    output logic at_speed_o,
    output logic valid_o,
    output logic [31:0] data_o
);
timeunit 1ns;
timeprecision 1ns;
int spin = 0;
logic [15:0] idx = 16'h0;
logic tick = 1'b0;
logic live;
initial begin
    at_speed_o = 1'b0;
    valid_o = 1'b0;
    data_o = 32'h0;
end
// spin-up and position are lost whenever the drive is unpowered
always @(posedge clock_i) begin
    tick <= ~tick;
    if (!power_i) begin
        spin <= 0;
        idx <= 16'h0;
    end else begin
        if (spin < SPIN) spin <= spin + 1;
        if (valid_o && ready_i) idx <= idx + 16'h1;
    end
end
// slow mode gaps every other word; idle data flips to its inverse every cycle instead of holding a stale word
assign live = power_i && spin >= SPIN && !(slow_i && tick);
always @(negedge clock_i) begin
    at_speed_o <= power_i && spin >= SPIN;
    valid_o <= live;
    data_o <= live ? {16'hc0de, idx} : ~data_o;
end
endmodule
`default_nettype wire

// File: verification/tb_microcode_load_sequencer.sv
`default_nettype none
module tb_microcode_load_sequencer;
timeunit 1ns;
timeprecision 1ns;
logic clock_i = 0, rst_b_i = 0, start_key_i = 0, diag_req_i = 0, ext_start_i = 0, slow = 1;
logic [15:0] image_words_i = 16'h2001;
logic drive_at_speed_i, disk_valid_i, disk_ready_o, drive_power_o, boot_load_lamp_o;
logic diag_active_o, cs_we_o, sys_reset_o, cpu_stopped_o;
logic [31:0] disk_data_i, cs_data_o;
logic [15:0] cs_addr_o;
logic [19:0] cs_alloc_o, ps_borrow_o;
int err_total = 0, n_compared = 0, nw = 0, cyc = 0;
always #25 clock_i = ~clock_i;
microcode_load_sequencer #(.RESET_CYCLES(16'h0002)) uut (.clock_i, .rst_b_i, .start_key_i,
    .diag_req_i, .ext_start_i, .image_words_i, .drive_at_speed_i, .disk_valid_i, .disk_data_i,
    .disk_ready_o, .drive_power_o, .boot_load_lamp_o, .diag_active_o, .cs_we_o, .cs_addr_o,
    .cs_data_o, .sys_reset_o, .cpu_stopped_o, .cs_alloc_o, .ps_borrow_o);
console_disk_model disk (.clock_i, .power_i(drive_power_o), .ready_i(disk_ready_o),
    .slow_i(slow), .at_speed_o(drive_at_speed_i), .valid_o(disk_valid_i), .data_o(disk_data_i));
task automatic close_out;
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
        err_total++;
        $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
endtask
// each write must carry the next image word to the next address
always @(negedge clock_i) begin
    if (cs_we_o === 1'b1) begin
        check(cs_addr_o, nw);
        check(cs_data_o, {16'hc0de, nw[15:0]});
        nw++;
    end
end
// watchdog: the run needs about 35000 cycles
always @(posedge clock_i) begin
    cyc++;
    if (cyc == 60000) begin
        err_total++;
        close_out;
    end
end
task automatic boot(input logic [15:0] w, input logic key, input logic s);
    logic [19:0] al;
    al = 20'h08000;
    if ({w, 2'b0} > al) al = ({2'b0, w, 2'b0} + 20'h007ff) & 20'hff800;
    nw = 0;
    image_words_i = w;
    slow = s;
    if (key) begin
        start_key_i = 1;
        repeat (2) @(negedge clock_i);
        start_key_i = 0;
    end
    while (boot_load_lamp_o !== 1'b1) @(negedge clock_i);
    check(drive_power_o, 32'h1);
    while (sys_reset_o !== 1'b1) @(negedge clock_i);
    check(drive_power_o, 32'h0);
    check(disk_ready_o, 32'h0);
    check(nw, w);
    check(cs_alloc_o, al);
    check(ps_borrow_o, al - 20'h08000);
    while (sys_reset_o === 1'b1) @(negedge clock_i);
    check(boot_load_lamp_o, 32'h0);
    repeat (5) @(negedge clock_i);
    check(cpu_stopped_o, 32'h1);
    ext_start_i = 1;
    repeat (4) @(negedge clock_i);
    ext_start_i = 0;
    check(cpu_stopped_o, 32'h0);
    repeat (4) @(negedge clock_i);
    check(cpu_stopped_o, 32'h0);
endtask
task automatic diag(input logic [15:0] w, input logic [19:0] al);
    nw = 0;
    image_words_i = w;
    diag_req_i = 1;
    repeat (2) @(negedge clock_i);
    diag_req_i = 0;
    while (diag_active_o !== 1'b1) @(negedge clock_i);
    check(drive_power_o, 32'h1);
    check(boot_load_lamp_o, 32'h0);
    while (diag_active_o === 1'b1) @(negedge clock_i);
    check(drive_power_o, 32'h0);
    check(sys_reset_o, 32'h0);
    check(cpu_stopped_o, 32'h1);
    check(nw, w);
    check(cs_alloc_o, al);
endtask
// power-up boot, two key boots across the 32768-byte base, a diagnostic load, then a zero-length key boot
initial begin
    repeat (6) @(negedge clock_i);
    check(drive_power_o, 32'h0);
    rst_b_i = 1;
    boot(16'h2001, 0, 1);
    boot(16'h2000, 1, 0);
    boot(16'h2200, 1, 0);
    diag(16'h0004, 20'h08800);
    boot(16'h0000, 1, 0);
    close_out;
end
endmodule
`default_nettype wire
